// [tb.sv]
`timescale 1ns/1ns
`default_nettype none

module tb;
    import usf_pkg::*;
    localparam usf_addr_type a_rx = 3'h0;
    localparam usf_addr_type a_tx = 3'h1;
    localparam usf_addr_type a_st = 3'h2;
    localparam usf_addr_type a_ct = 3'h3;
    typedef struct {
        logic [2:0] kind;
        logic [15:0] exp;
    } usf_row_type;
    usf_row_type rows [6];
    logic [15:0] ena [4] = '{16'h0001, 16'h0100, 16'h0040, 16'h0002};
    logic [2:0] ek [4] = '{3'h1, 3'h2, 3'h0, 3'h3};
    logic [15:0] ix [4] = '{16'h0001, 16'h0001, 16'h0001, 16'h0000};
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    usf_addr_type reg_addr = 3'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic rx_load = 1'b0;
    logic [7:0] rx_char = 8'h33;
    logic [2:0] evt_sel = 3'h0;
    logic clear_to_send_n = 1'b1;
    logic [3:0] take_delay = 4'h2;
    logic [15:0] reg_rdata;
    logic [7:0] tx_hold_data;
    logic [7:0] last_char;
    logic [15:0] got;
    logic tx_take;
    logic tx_shift_idle;
    logic tx_hold_full;
    logic irq;
    logic rts_n;
    logic tx_brk;
    int errors = 0;
    int num_checks = 0;
    int cycles = 0;

    usf_status_flags_upper u_usf_status_flags_upper (
        .sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .tx_take(tx_take),
        .tx_shift_idle(tx_shift_idle), .tx_hold_data(tx_hold_data),
        .tx_hold_full(tx_hold_full), .rx_load(rx_load), .rx_char(rx_char),
        .parity_error_evt(evt_sel == 3'h1),
        .framing_error_evt(evt_sel == 3'h2),
        .line_break_evt(evt_sel == 3'h3),
        .clear_to_send_n(clear_to_send_n), .request_to_send_n(rts_n),
        .tx_break(tx_brk), .irq(irq));
    usf_line_model u_usf_line_model (
        .sys_clk(sys_clk), .reset(reset), .tx_hold_full(tx_hold_full),
        .tx_hold_data(tx_hold_data), .take_delay(take_delay),
        .tx_take(tx_take), .tx_shift_idle(tx_shift_idle),
        .last_char(last_char));

    always #25 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors = errors + 1;
            end_of_test();
        end
    end

    task automatic end_of_test();
        if (errors == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        num_checks++;
        if (g !== e) begin
            errors++;
            $display("ERROR %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic bus(input logic w, input logic r, input usf_addr_type a,
        input logic [15:0] d);
        @(posedge sys_clk);
        reg_write <= w;
        reg_read <= r;
        reg_addr <= a;
        reg_wdata <= d;
    endtask
    task automatic wr(input usf_addr_type a, input logic [15:0] d);
        bus(1'b1, 1'b0, a, d);
        bus(1'b0, 1'b0, a, 16'h0000);
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
        got = reg_rdata;
    endtask
    // Drop the strobe at the edge that takes it, then grab the data
    task automatic fetch();
        bus(1'b0, 1'b0, reg_addr, 16'h0000);
        #1;
        got = reg_rdata;
    endtask
    task automatic rd(input usf_addr_type a);
        bus(1'b0, 1'b1, a, 16'h0000);
        fetch();
    endtask
    // Write zero or read at a, then a status read with no gap
    task automatic pair(input logic w, input usf_addr_type a);
        bus(w, !w, a, 16'h0000);
        bus(1'b0, 1'b1, a_st, 16'h0000);
        fetch();
    endtask
    // Kind 4 loads twice, 5 writes twice, 6 loads once
    task automatic evt(input logic [2:0] k);
        if (k == 3'h5) begin
            bus(1'b1, 1'b0, a_tx, 16'h0041);
            take_delay <= 4'hF;
            bus(1'b1, 1'b0, a_tx, 16'h0042);
        end else begin
            @(posedge sys_clk);
            evt_sel <= k;
            rx_load <= k == 3'h4 || k == 3'h6;
            rx_char <= (k == 3'h6) ? 8'h7E : 8'h33;
            if (k == 3'h4) @(posedge sys_clk);
            @(posedge sys_clk);
            evt_sel <= 3'h0;
            rx_load <= 1'b0;
        end
        bus(1'b0, 1'b0, a_tx, 16'h0000);
    endtask
    task automatic wait_empty();
        for (int n = 0; n < 64 && tx_hold_full !== 1'b0; n++)
            @(negedge sys_clk);
        chk({15'h0000, tx_hold_full}, 16'h0000);
    endtask

    initial begin
        rows[0] = '{3'h0, 16'h0040};
        rows[1] = '{3'h1, 16'h0141};
        rows[2] = '{3'h2, 16'h0142};
        rows[3] = '{3'h3, 16'h0144};
        rows[4] = '{3'h4, 16'h01C8};
        rows[5] = '{3'h5, 16'h0110};
        repeat (5) @(posedge sys_clk);
        reset <= 1'b0;
        rd(a_st);
        chk(got, 16'h0060);
        chk({14'h0000, rts_n, tx_brk}, 16'h0002);
        wr(3'h4, 16'h1FFF);
        rd(3'h4);
        chk(got, 16'h0000);
        for (int i = 0; i < 6; i++) begin
            pair(1'b1, a_st);
            chk(got & 16'h011F, 16'h0000);
            evt(rows[i].kind);
            rd(a_st);
            chk(got & 16'h11DF, rows[i].exp);
            if (rows[i].kind == 3'h4) begin
                rd(a_rx);
                chk(got, 16'h0033);
            end
            wait_empty();
        end
        chk({8'h00, last_char}, 16'h0042);
        @(posedge sys_clk);
        take_delay <= 4'h2;
        wr(3'h5, 16'h007E);
        rd(a_st);
        chk(got & 16'h0040, 16'h0040);
        wr(a_tx, 16'h007E);
        wait_empty();
        pair(1'b0, a_st);
        chk(got & 16'h1000, 16'h1000);
        pair(1'b1, a_st);
        chk(got & 16'h1010, 16'h0000);
        evt(3'h6);
        rd(a_st);
        chk(got & 16'h0080, 16'h0080);
        pair(1'b0, a_rx);
        chk(got & 16'h1080, 16'h1000);
        @(posedge sys_clk);
        clear_to_send_n <= 1'b0;
        repeat (8) @(posedge sys_clk);
        wr(a_ct, 16'h0400);
        rd(a_st);
        chk(got & 16'h0C00, 16'h0C00);
        chk({15'h0000, irq}, 16'h0001);
        pair(1'b1, a_st);
        chk(got & 16'h0C00, 16'h0800);
        chk({15'h0000, irq}, 16'h0000);
        @(posedge sys_clk);
        clear_to_send_n <= 1'b1;
        repeat (8) @(posedge sys_clk);
        rd(a_st);
        chk(got & 16'h0C00, 16'h0400);
        for (int i = 0; i < 4; i++) begin
            wr(a_ct, ena[i]);
            evt(ek[i]);
            settle(2);
            chk({15'h0000, irq}, ix[i]);
            wr(a_ct, 16'h0000);
            settle(2);
            chk({15'h0000, irq}, 16'h0000);
            pair(1'b1, a_st);
        end
        wr(a_ct, 16'h0A40);
        settle(2);
        chk({13'h0000, rts_n, tx_brk, irq}, 16'h0003);
        rd(a_ct);
        chk(got, 16'h0A40);
        @(posedge sys_clk);
        reset <= 1'b1;
        @(posedge sys_clk);
        #1;
        chk({13'h0000, rts_n, tx_brk, irq}, 16'h0004);
        @(posedge sys_clk);
        reset <= 1'b0;
        rd(a_st);
        chk(got, 16'h0060);
        rd(a_ct);
        chk(got, 16'h0000);
        end_of_test();
    end
endmodule // tb

`default_nettype wire

// [usf_irq_combine.sv]
`timescale 1ns/1ns
`default_nettype none
`include "usf_map.svh"

module usf_irq_combine (
    input wire logic sys_clk,
    input wire logic reset,
    usf_irq_if.combiner bus
);
    import usf_pkg::*;

    logic irq_reg;

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(bus.flags & bus.enables & `USF_ENA_MASK);
        end
    end

    assign bus.irq = irq_reg;
endmodule // usf_irq_combine

`default_nettype wire

// [usf_irq_if.sv]
`timescale 1ns/1ns
`default_nettype none

interface usf_irq_if;
    import usf_pkg::*;
    usf_word_type flags;
    usf_word_type enables;
    logic irq;
    modport owner (output flags, output enables, input irq);
    modport combiner (input flags, input enables, output irq);
endinterface

`default_nettype wire

// [usf_line_model.sv]
`timescale 1ns/1ns
`default_nettype none

// Shifter side; a long delay lets the host overrun the holding register
module usf_line_model (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic tx_hold_full,
    input wire logic [7:0] tx_hold_data,
    input wire logic [3:0] take_delay,
    output logic tx_take,
    output logic tx_shift_idle,
    output logic [7:0] last_char
);
    logic [3:0] wait_reg;
    logic [3:0] shift_reg;
    assign tx_shift_idle = shift_reg == 4'h0;
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            wait_reg <= 4'h0;
            shift_reg <= 4'h0;
            tx_take <= 1'b0;
            last_char <= 8'h00;
        end else begin
            tx_take <= 1'b0;
            if (!tx_shift_idle) begin
                shift_reg <= shift_reg - 4'h1;
            end else if (tx_hold_full) begin
                wait_reg <= wait_reg + 4'h1;
                if (wait_reg == take_delay) begin
                    tx_take <= 1'b1;
                    last_char <= tx_hold_data;
                    shift_reg <= 4'h8;
                    wait_reg <= 4'h0;
                end
            end
        end
    end
endmodule // usf_line_model

`default_nettype wire

// [usf_map.svh]
`ifndef USF_MAP_SVH
`define USF_MAP_SVH

// Register index on the 3-bit register address
`define USF_ADDR_W 3
`define USF_OFS_RXDATA 3'h0
`define USF_OFS_TXDATA 3'h1
`define USF_OFS_LINE_STATUS 3'h2
`define USF_OFS_CONTROL 3'h3
`define USF_OFS_EOP_CHAR 3'h5

// Line status / control field positions
`define USF_STAT_W 13
`define USF_BIT_PE 0
`define USF_BIT_FE 1
`define USF_BIT_BRK 2
`define USF_BIT_ROE 3
`define USF_BIT_TOE 4
`define USF_BIT_TMT 5
`define USF_BIT_TRDY 6
`define USF_BIT_RRDY 7
`define USF_BIT_ERR 8
`define USF_BIT_TBRK 9
`define USF_BIT_PERMIT_CHANGE_FLAG 10
`define USF_BIT_CTS 11
`define USF_BIT_EOP 12
`define USF_BIT_RTS 11

// Reset values and masks
`define USF_CTRL_RST 13'h0000
`define USF_CTRL_WMASK 13'h1FFF
`define USF_ENA_MASK 13'h15FF
`define USF_EOP_RST 9'h000
`define USF_CHAR_RST 9'h000

`endif

// [usf_pin_sync.sv]
`timescale 1ns/1ns
`default_nettype none

module usf_pin_sync #(
    parameter logic IDLE_LEVEL = 1'b1
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic pin_in,
    output logic level,
    output logic changed
);
    logic stage1_reg;
    logic stage2_reg;
    logic stage3_reg;
    logic level_reg;
    logic changed_reg;

    // First stage feeds only the second
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            stage1_reg <= IDLE_LEVEL;
            stage2_reg <= IDLE_LEVEL;
            stage3_reg <= IDLE_LEVEL;
        end else begin
            stage1_reg <= pin_in;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
        end
    end

    // Accept a new level only once stages two and three agree
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            level_reg <= IDLE_LEVEL;
            changed_reg <= 1'b0;
        end else begin
            changed_reg <= (stage2_reg == stage3_reg)
                && (stage3_reg != level_reg);
            if (stage2_reg == stage3_reg) begin
                level_reg <= stage3_reg;
            end
        end
    end

    assign level = level_reg;
    assign changed = changed_reg;
endmodule // usf_pin_sync

`default_nettype wire

// [usf_pkg.sv]
`default_nettype none
`include "usf_map.svh"

package usf_pkg;

    typedef logic [`USF_ADDR_W-1:0] usf_addr_type;
    typedef logic [`USF_STAT_W-1:0] usf_word_type;

    typedef enum logic [2:0] {
        USF_SEL_NONE = 3'h0,
        USF_SEL_RX = 3'h1,
        USF_SEL_TX = 3'h3,
        USF_SEL_STAT = 3'h2,
        USF_SEL_CTRL = 3'h6,
        USF_SEL_EOP = 3'h7
    } usf_sel_type;

    function automatic usf_sel_type usf_decode(input usf_addr_type addr);
        usf_sel_type sel;
        sel = USF_SEL_NONE;
        case (addr)
            `USF_OFS_RXDATA: sel = USF_SEL_RX;
            `USF_OFS_TXDATA: sel = USF_SEL_TX;
            `USF_OFS_LINE_STATUS: sel = USF_SEL_STAT;
            `USF_OFS_CONTROL: sel = USF_SEL_CTRL;
            `USF_OFS_EOP_CHAR: sel = USF_SEL_EOP;
            default: sel = USF_SEL_NONE;
        endcase
        return sel;
    endfunction

    // Set beats clear so a same-cycle event is never lost
    function automatic logic usf_sticky(input logic set, input logic hold,
                                        input logic clr);
        return set | (hold & ~clr);
    endfunction

endpackage

`default_nettype wire

// [usf_status_checker.sv]
`timescale 1ns/1ns
`default_nettype none

module usf_status_checker #(
    parameter int DATA_W = 16
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire usf_pkg::usf_addr_type reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic tx_hold_full,
    input wire logic rx_load,
    input wire logic parity_error_evt,
    input wire logic framing_error_evt,
    input wire logic line_break_evt,
    input wire logic irq
);
    import usf_pkg::*;
    logic rd_st;
    logic wr_st;
    logic wr_ct;
    logic no_evt;
    assign rd_st = reg_read && reg_addr == 3'h2;
    assign wr_st = reg_write && reg_addr == 3'h2;
    assign wr_ct = reg_write && reg_addr == 3'h3;
    // Events in the clearing cycle win over the clear
    assign no_evt = !(rx_load | parity_error_evt | framing_error_evt
        | line_break_evt);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    trdy_level_a: assert property (rd_st
        |=> reg_rdata[6] == !$past(tx_hold_full)) else $error("bit 6");
    tx_fill_a: assert property (reg_write && reg_addr == 3'h1
        |=> tx_hold_full) else $error("hold not full");
    rrdy_clear_a: assert property (reg_read && reg_addr == 3'h0
        && !rx_load ##1 rd_st |=> !reg_rdata[7]) else $error("bit 7");
    err_sum_a: assert property (rd_st
        |=> reg_rdata[8] == |reg_rdata[4:0]) else $error("bit 8");
    flags_hold_a: assert property (rd_st ##1 rd_st
        |=> ($past(reg_rdata[12:0]) & 13'h141F & ~reg_rdata[12:0])
        == 13'h0000) else $error("sticky flag lost");
    stat_clear_a: assert property (wr_st && no_evt ##1 rd_st
        |=> reg_rdata[4:0] == 5'h00 && !reg_rdata[8])
        else $error("status not cleared");
    irq_drop_a: assert property (wr_ct && reg_wdata[12:0] == 13'h0
        |=> ##1 !irq) else $error("irq held");
    irq_rise_a: assert property (wr_ct && reg_wdata[6]
        ##1 !tx_hold_full |=> irq) else $error("irq missing");

    cover property (rd_st ##1 reg_rdata[10]);
    cover property ($rose(irq));
    cover property (wr_st ##1 rd_st);
endmodule // usf_status_checker

bind usf_status_flags_upper usf_status_checker #(.DATA_W(DATA_W)) u_chk (
    .sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .tx_hold_full(tx_hold_full), .rx_load(rx_load),
    .parity_error_evt(parity_error_evt), .line_break_evt(line_break_evt),
    .framing_error_evt(framing_error_evt), .irq(irq));

`default_nettype wire

// [usf_status_flags_upper.sv]
// Strobed register access and the register addresses were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "usf_map.svh"

// Summary of operation
// - Bit 6 reads 1 while the transmit holding register is empty.
// - Bit 7 sets when a received character loads; 0 while empty.
// - A host read of the receive holding register clears bit 7 unless a character loads in the same cycle.
// - Bit 8 is the OR of the five sticky error flags.
// - Each error flag has its own enable bit; the bit 8 enable covers every error together.
// - Bit 10 sets on either edge of the synchronised clear-to-send pin.
// - The change flag holds 1 until a host write to the status word.
// - Bit 11 shows the inverted synchronised clear-to-send pin level.
// - Clear-to-send never affects transmit or receive; only flags and irq.
// - Change flag with its enable raises an interrupt request.
// - Without flow control, bits 10 and 11 read 0.
// - Bit 12 sets when the end-of-packet character is written or read.
// - The end-of-packet flag holds 1 until a status word write.
// - Without the end-of-packet option, bit 12 reads 0.
// - Bits 10, 11 and 12 are build options that may be absent.
// - Writing zero to the status word clears all sticky flags.
// - Status word reads are allowed anytime and change nothing.
// - Any flag other than bit 11 with its same-position enable set requests an interrupt.

module usf_status_flags_upper #(
    parameter int DATA_W = 16,
    parameter int CHAR_W = 8,
    parameter bit FLOW_CTRL_EN = 1'b1,
    parameter bit EOP_EN = 1'b1
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire usf_pkg::usf_addr_type reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [DATA_W-1:0] reg_rdata,
    input wire logic tx_take,
    input wire logic tx_shift_idle,
    output logic [CHAR_W-1:0] tx_hold_data,
    output logic tx_hold_full,
    input wire logic rx_load,
    input wire logic [CHAR_W-1:0] rx_char,
    input wire logic parity_error_evt,
    input wire logic framing_error_evt,
    input wire logic line_break_evt,
    input wire logic clear_to_send_n,
    output logic request_to_send_n,
    output logic tx_break,
    output logic irq
);
    import usf_pkg::*;

    // Character and bus widths the field layout can carry
    if (CHAR_W < 5 || CHAR_W > 9 || DATA_W < `USF_STAT_W
        || DATA_W < CHAR_W) begin : g_bad_cfg
        $error("usf: unsupported width parameters");
    end

    usf_sel_type sel;
    logic wr_tx;
    logic wr_stat;
    logic wr_ctrl;
    logic wr_eop;
    logic rd_rx;

    logic [CHAR_W-1:0] tx_data_reg;
    logic tx_full_reg;
    logic [CHAR_W-1:0] rx_data_reg;
    logic rx_ready_reg;

    logic parity_error_flag_reg;
    logic framing_error_flag_reg;
    logic line_break_flag_reg;
    logic rx_overrun_flag_reg;
    logic tx_overrun_flag_reg;
    logic permit_change_flag_reg;
    logic packet_end_seen_flag_reg;

    usf_word_type ctrl_reg;
    logic [CHAR_W-1:0] eop_char_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic rts_n_reg;
    logic tx_break_reg;

    logic cts_level_n;
    logic cts_changed;
    logic error_any;
    logic eop_hit_tx;
    logic eop_hit_rx;
    usf_word_type line_status;
    usf_word_type ctrl_view;

    usf_irq_if irq_bus ();

    always_comb begin
        sel = usf_decode(reg_addr);
    end

    assign wr_tx = reg_write && (sel == USF_SEL_TX);
    assign wr_stat = reg_write && (sel == USF_SEL_STAT);
    assign wr_ctrl = reg_write && (sel == USF_SEL_CTRL);
    assign wr_eop = reg_write && (sel == USF_SEL_EOP);
    assign rd_rx = reg_read && (sel == USF_SEL_RX);

    // Pin comes from outside the clock domain
    usf_pin_sync #(
        .IDLE_LEVEL(1'b1)
    ) u_cts_sync (
        .sys_clk(sys_clk),
        .reset(reset),
        .pin_in(clear_to_send_n),
        .level(cts_level_n),
        .changed(cts_changed)
    );

    // Transmit holding register; overwritten even while full
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            tx_data_reg <= CHAR_W'(`USF_CHAR_RST);
        end else if (wr_tx) begin
            tx_data_reg <= reg_wdata[CHAR_W-1:0];
        end
    end

    // ready tracks empty
    // A write wins over a take so the new character is never lost
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            tx_full_reg <= 1'b0;
        end else if (wr_tx) begin
            tx_full_reg <= 1'b1;
        end else if (tx_take) begin
            tx_full_reg <= 1'b0;
        end
    end

    // Receive holding register always takes the new character
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rx_data_reg <= CHAR_W'(`USF_CHAR_RST);
        end else if (rx_load) begin
            rx_data_reg <= rx_char;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rx_ready_reg <= 1'b0;
        end else begin
            rx_ready_reg <= usf_sticky(rx_load, rx_ready_reg, rd_rx);
        end
    end

    // Receiver error events
    // write clears sticky
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            parity_error_flag_reg <= 1'b0;
            framing_error_flag_reg <= 1'b0;
            line_break_flag_reg <= 1'b0;
        end else begin
            parity_error_flag_reg <= usf_sticky(parity_error_evt,
                parity_error_flag_reg, wr_stat);
            framing_error_flag_reg <= usf_sticky(framing_error_evt,
                framing_error_flag_reg, wr_stat);
            line_break_flag_reg <= usf_sticky(line_break_evt,
                line_break_flag_reg, wr_stat);
        end
    end

    // Receive overrun: a load while the last character is unread
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rx_overrun_flag_reg <= 1'b0;
        end else begin
            rx_overrun_flag_reg <= usf_sticky(rx_load && rx_ready_reg,
                rx_overrun_flag_reg, wr_stat);
        end
    end

    // Transmit overrun: a write while full and not taken that cycle
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            tx_overrun_flag_reg <= 1'b0;
        end else begin
            tx_overrun_flag_reg <= usf_sticky(
                wr_tx && tx_full_reg && !tx_take,
                tx_overrun_flag_reg, wr_stat);
        end
    end

    assign error_any = parity_error_flag_reg | framing_error_flag_reg
        | line_break_flag_reg | rx_overrun_flag_reg | tx_overrun_flag_reg;

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            permit_change_flag_reg <= 1'b0;
        end else if (FLOW_CTRL_EN) begin
            permit_change_flag_reg <= usf_sticky(cts_changed,
                permit_change_flag_reg, wr_stat);
        end else begin
            permit_change_flag_reg <= 1'b0;
        end
    end

    // Shared by both paths; the read side sees the old content
    function automatic logic eop_match(input logic [CHAR_W-1:0] ch,
                                       input logic [CHAR_W-1:0] mark);
        return ch == mark;
    endfunction

    assign eop_hit_tx = wr_tx
        && eop_match(reg_wdata[CHAR_W-1:0], eop_char_reg);
    assign eop_hit_rx = rd_rx && eop_match(rx_data_reg, eop_char_reg);

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            packet_end_seen_flag_reg <= 1'b0;
        end else if (EOP_EN) begin
            packet_end_seen_flag_reg <= usf_sticky(eop_hit_tx | eop_hit_rx,
                packet_end_seen_flag_reg, wr_stat);
        end else begin
            packet_end_seen_flag_reg <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            eop_char_reg <= CHAR_W'(`USF_EOP_RST);
        end else if (wr_eop && EOP_EN) begin
            eop_char_reg <= reg_wdata[CHAR_W-1:0];
        end
    end

    // Control: interrupt enables, break and request-to-send
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            ctrl_reg <= `USF_CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_reg <= reg_wdata[`USF_STAT_W-1:0] & `USF_CTRL_WMASK;
        end
    end

    // Request-to-send bit is absent without flow control
    always_comb begin
        ctrl_view = ctrl_reg;
        if (!FLOW_CTRL_EN) begin
            ctrl_view[`USF_BIT_RTS] = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rts_n_reg <= 1'b1;
            tx_break_reg <= 1'b0;
        end else begin
            rts_n_reg <= ~ctrl_view[`USF_BIT_RTS];
            tx_break_reg <= ctrl_view[`USF_BIT_TBRK];
        end
    end

    always_comb begin
        line_status = '0;
        line_status[`USF_BIT_PE] = parity_error_flag_reg;
        line_status[`USF_BIT_FE] = framing_error_flag_reg;
        line_status[`USF_BIT_BRK] = line_break_flag_reg;
        line_status[`USF_BIT_ROE] = rx_overrun_flag_reg;
        line_status[`USF_BIT_TOE] = tx_overrun_flag_reg;
        line_status[`USF_BIT_TMT] = tx_shift_idle;
        line_status[`USF_BIT_TRDY] = ~tx_full_reg;
        line_status[`USF_BIT_RRDY] = rx_ready_reg;
        line_status[`USF_BIT_ERR] = error_any;
        line_status[`USF_BIT_PERMIT_CHANGE_FLAG] = permit_change_flag_reg;
        line_status[`USF_BIT_CTS] = FLOW_CTRL_EN & ~cts_level_n;
        line_status[`USF_BIT_EOP] = packet_end_seen_flag_reg;
    end

    // status reads have no side effect on flags; receive reads clear bit 7 and may set bit 12
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rdata_reg <= '0;
        end else if (reg_read) begin
            case (sel)
                USF_SEL_RX: rdata_reg <= DATA_W'(rx_data_reg);
                USF_SEL_STAT: rdata_reg <= DATA_W'(line_status);
                USF_SEL_CTRL: rdata_reg <= DATA_W'(ctrl_view);
                USF_SEL_EOP: rdata_reg <= EOP_EN ? DATA_W'(eop_char_reg)
                    : '0;
                default: rdata_reg <= '0;
            endcase
        end else begin
            rdata_reg <= '0;
        end
    end

    assign irq_bus.flags = line_status;
    assign irq_bus.enables = ctrl_view;

    usf_irq_combine u_irq (
        .sys_clk(sys_clk),
        .reset(reset),
        .bus(irq_bus.combiner)
    );

    assign reg_rdata = rdata_reg;
    assign tx_hold_data = tx_data_reg;
    assign tx_hold_full = tx_full_reg;
    assign request_to_send_n = rts_n_reg;
    assign tx_break = tx_break_reg;
    assign irq = irq_bus.irq;
endmodule // usf_status_flags_upper

`default_nettype wire
